/* File: hdl/rpc_hub.sv */
`timescale 1ns/100ps
`default_nettype none

module rpc_hub
    import rpc_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            arst_n,
    input  wire logic            acc_valid,
    input  wire logic            acc_write,
    input  wire logic            acc_bcc,
    input  wire logic [1:0]      acc_port,
    input  wire logic [7:0]      acc_addr,
    input  wire logic [7:0]      acc_wdata,
    output logic      [7:0]      rd_data,
    output logic                 rd_valid,
    input  wire logic            enhanced_error_check_en,
    input  wire logic [3:0]      port_seq_err,
    input  wire logic [3:0]      seq_err_evt,
    input  wire logic [3:0]      enc_crc_err,
    output logic      [3:0]      enc_crc_flag,
    input  wire logic [3:0]      raw_mode,
    input  wire logic [3:0]      frame_start,
    input  wire logic [3:0]      long_pkt,
    input  wire logic [3:0][5:0] csi_dtype,
    input  wire logic [3:0]      raw12_sel,
    input  wire logic [3:0][5:0] raw10_type_value,
    input  wire logic [3:0][5:0] raw12_type_value,
    output logic      [3:0][5:0] pkt_dtype,
    output logic      [3:0]      pkt_valid,
    input  wire logic [3:0]      resp_valid,
    input  wire logic [3:0][7:0] resp_expected,
    input  wire logic [3:0][7:0] resp_returned
);

    // ==========================================================
    // Helpers
    function automatic logic [2:0] src_index(input logic bcc,
                                             input logic [1:0] port);
        src_index = bcc ? {1'b0, port} + 3'h1 : 3'h0;
    endfunction

    function automatic logic is_paged(input logic [7:0] a);
        is_paged = (a == ADDR_CC_STATUS) || (a == ADDR_LINK_CAP) ||
                   (a == ADDR_RAW_EMBED) ||
                   (a >= ADDR_PAGE_LO && a <= ADDR_PAGE_HI) ||
                   (a >= ADDR_PAGE2_LO && a <= ADDR_PAGE2_HI);
    endfunction

    rpc_state_t st_q;
    rpc_state_t st_d;
    logic [2:0] src;
    logic [1:0] rport;
    logic [3:0] lane_resp;
    logic       rd_req;
    logic       wr_req;

    assign src    = src_index(acc_bcc, acc_port);
    assign rport  = st_q.rd_sel[src];
    assign rd_req = acc_valid && !acc_write;
    assign wr_req = acc_valid && acc_write;

    // ==========================================================
    // Per-port packet lanes
    rpc_lane_if lif [NUM_PORTS] ();

    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_lane
            assign lif[g].embed_cnt = st_q.embed[g][7:6];
            assign lif[g].embed_val = st_q.embed[g][5:0];
            assign lif[g].enh_en    = enhanced_error_check_en;
            assign lane_resp[g]     = lif[g].resp_err;
            assign pkt_dtype[g]     = lif[g].dtype;
            assign pkt_valid[g]     = lif[g].dtype_valid;

            rpc_lane u_lane (
                .sys_clk          (sys_clk),
                .arst_n           (arst_n),
                .cfg              (lif[g]),
                .raw_mode         (raw_mode[g]),
                .frame_start      (frame_start[g]),
                .long_pkt         (long_pkt[g]),
                .csi_dtype        (csi_dtype[g]),
                .raw12_sel        (raw12_sel[g]),
                .raw10_type_value (raw10_type_value[g]),
                .raw12_type_value (raw12_type_value[g]),
                .resp_valid       (resp_valid[g]),
                .resp_expected    (resp_expected[g]),
                .resp_returned    (resp_returned[g])
            );
        end
    endgenerate

    // ==========================================================
    // Register file
    always_comb begin
        st_d = st_q;
        st_d.rd_valid = rd_req;
        st_d.crc_flag = enc_crc_err & st_q.crc_cap;

        if (rd_req) begin
            st_d.rd_data = 8'h00;
            if (acc_addr == ADDR_PAGE_SEL) begin
                st_d.rd_data[7:6] = acc_bcc ? acc_port : 2'h0;
                st_d.rd_data[5:4] = st_q.rd_sel[src];
                st_d.rd_data[3:0] = st_q.wr_en[src];
            end else if (acc_addr == ADDR_CC_STATUS) begin
                // Mirror is live only while enhanced checking is off
                st_d.rd_data[STS_SEQ_BIT] = enhanced_error_check_en
                    ? st_q.seq_err[rport]
                    : port_seq_err[rport];
                st_d.rd_data[STS_RESP_BIT] = enhanced_error_check_en &&
                    st_q.resp_err[rport];
                st_d.resp_err[rport] = 1'b0;
                if (enhanced_error_check_en) begin
                    st_d.seq_err[rport] = 1'b0;
                end
            end else if (acc_addr == ADDR_LINK_CAP) begin
                st_d.rd_data[CAP_CRC_EN_BIT] = st_q.crc_cap[rport];
            end else if (acc_addr == ADDR_RAW_EMBED) begin
                st_d.rd_data = st_q.embed[rport];
            end
        end

        if (wr_req) begin
            if (acc_addr == ADDR_PAGE_SEL) begin
                st_d.rd_sel[src] = acc_wdata[5:4];
                st_d.wr_en[src]  = acc_wdata[3:0];
            end else if (is_paged(acc_addr)) begin
                // Broadcast: every enabled port takes the same raw embed byte or link cap bit
                for (int p = 0; p < NUM_PORTS; p++) begin
                    if (st_q.wr_en[src][p]) begin
                        if (acc_addr == ADDR_LINK_CAP) begin
                            st_d.crc_cap[p] = acc_wdata[CAP_CRC_EN_BIT];
                        end else if (acc_addr == ADDR_RAW_EMBED) begin
                            st_d.embed[p] = acc_wdata;
                        end
                    end
                end
            end
        end

        // Events set after the read clear so a same-cycle event survives
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (lane_resp[p]) begin
                st_d.resp_err[p] = 1'b1;
            end
            if (enhanced_error_check_en && seq_err_evt[p]) begin
                st_d.seq_err[p] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= RPC_STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data      = st_q.rd_data;
    assign rd_valid     = st_q.rd_valid;
    assign enc_crc_flag = st_q.crc_flag;

    // ==========================================================
    // Checks
    logic [7:0] embed_pre;
    assign embed_pre = st_q.embed[0];

    a_phys_port_bcc: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        rd_req && acc_bcc && acc_addr == ADDR_PAGE_SEL
        |=> rd_valid && rd_data[7:6] == $past(acc_port))
        else $error("physical port field wrong on channel read");

    a_phys_port_local: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        rd_req && !acc_bcc && acc_addr == ADDR_PAGE_SEL
        |=> rd_data[7:6] == 2'h0)
        else $error("physical port field not zero locally");

    a_resp_clear_read: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        rd_req && acc_addr == ADDR_CC_STATUS && lane_resp == 4'h0
        |=> st_q.resp_err[$past(rport)] == 1'b0)
        else $error("response flag not cleared by read");

    a_resp_gated: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        rd_req && acc_addr == ADDR_CC_STATUS && !enhanced_error_check_en
        |=> rd_data[STS_RESP_BIT] == 1'b0)
        else $error("response flag shown while checking off");

    a_crc_flag_gate: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> enc_crc_flag == ($past(enc_crc_err) & $past(st_q.crc_cap)))
        else $error("encoder crc flag not gated by capability");

    a_no_enable_hold: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        wr_req && is_paged(acc_addr) && st_q.wr_en[src] == 4'h0
        |=> $stable(st_q.embed) && $stable(st_q.crc_cap))
        else $error("paged write landed with no enable");

    a_cap_reserved: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        rd_req && acc_addr == ADDR_LINK_CAP
        |=> rd_data[7:5] == 3'h0 && rd_data[3:0] == 4'h0)
        else $error("reserved capability bits nonzero");

    a_seq_mirror: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        rd_req && acc_addr == ADDR_CC_STATUS && !enhanced_error_check_en
        |=> rd_data[STS_SEQ_BIT] == $past(port_seq_err[rport]))
        else $error("sequence bit does not mirror port status");

    a_port0_write: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        wr_req && acc_addr == ADDR_RAW_EMBED && st_q.wr_en[src][0]
        |=> embed_pre == $past(acc_wdata))
        else $error("enabled port 0 missed broadcast write");

    a_read_port_sel: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        rd_req && acc_addr == ADDR_RAW_EMBED
        |=> rd_data == $past(st_q.embed[rport]))
        else $error("read returned wrong port page");

    a_sel_own_copy: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        wr_req && acc_addr == ADDR_PAGE_SEL
        |=> st_q.rd_sel[$past(src)] == $past(acc_wdata[5:4]) &&
            st_q.wr_en[$past(src)] == $past(acc_wdata[3:0]))
        else $error("page select write missed own copy");

    a_sel_local_apart: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        wr_req && !acc_bcc && acc_addr == ADDR_PAGE_SEL
        |=> $stable(st_q.rd_sel[4:1]) && $stable(st_q.wr_en[4:1]))
        else $error("local page write disturbed channel copies");

    a_rd_valid_set: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        rd_req |=> rd_valid)
        else $error("read answer missing");

    a_rd_valid_quiet: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !rd_req |=> !rd_valid)
        else $error("read answer without request");

    a_resp_sticky: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        lane_resp != 4'h0
        |=> (st_q.resp_err & $past(lane_resp)) == $past(lane_resp))
        else $error("response error not held");

    a_seq_sticky: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        enhanced_error_check_en && seq_err_evt != 4'h0
        |=> (st_q.seq_err & $past(seq_err_evt)) == $past(seq_err_evt))
        else $error("sequence error not held");

    a_seq_off_quiet: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !enhanced_error_check_en |=> $stable(st_q.seq_err))
        else $error("sequence flag moved while checking off");

    a_cap_read_bit: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        rd_req && acc_addr == ADDR_LINK_CAP
        |=> rd_data[CAP_CRC_EN_BIT] == $past(st_q.crc_cap[rport]))
        else $error("capability bit read wrong port");

    a_page_range_zero: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        rd_req && acc_addr >= ADDR_PAGE_LO && acc_addr <= ADDR_PAGE_HI
        |=> rd_data == 8'h00)
        else $error("empty paged offset read nonzero");

    a_sts_reserved: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        rd_req && acc_addr == ADDR_CC_STATUS
        |=> rd_data[7:6] == 2'h0 && rd_data[4:1] == 4'h0)
        else $error("reserved status bits nonzero");

endmodule
`default_nettype wire

/* File: hdl/rpc_lane.sv */
`timescale 1ns/100ps
`default_nettype none
module rpc_lane
    import rpc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    rpc_lane_if.lane        cfg,
    input  wire logic       raw_mode,
    input  wire logic       frame_start,
    input  wire logic       long_pkt,
    input  wire logic [5:0] csi_dtype,
    input  wire logic       raw12_sel,
    input  wire logic [5:0] raw10_type_value,
    input  wire logic [5:0] raw12_type_value,
    input  wire logic       resp_valid,
    input  wire logic [7:0] resp_expected,
    input  wire logic [7:0] resp_returned
);

    rpc_lane_state_t st_q;
    rpc_lane_state_t st_d;
    logic [1:0]      cnt_now;

    // Frame start restarts the count even when a packet shares the cycle
    assign cnt_now = frame_start ? 2'h0 : st_q.pkt_cnt;

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.dtype_valid = long_pkt;
        st_d.pkt_cnt = cnt_now;
        // Mismatch only counts with enhanced checking on
        st_d.resp_err = resp_valid && cfg.enh_en &&
                        (resp_returned != resp_expected);
        if (long_pkt) begin
            if (!raw_mode) begin
                st_d.dtype = csi_dtype;
            end else if (cnt_now < cfg.embed_cnt) begin
                st_d.dtype = cfg.embed_val;
            end else begin
                st_d.dtype = raw12_sel ? raw12_type_value
                                       : raw10_type_value;
            end
            // Saturate: at most three leading packets are marked
            if (cnt_now != 2'h3) begin
                st_d.pkt_cnt = cnt_now + 2'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= RPC_LANE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign cfg.resp_err    = st_q.resp_err;
    assign cfg.dtype       = st_q.dtype;
    assign cfg.dtype_valid = st_q.dtype_valid;

    // ==========================================================
    // Checks
    a_embed_type_used: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        long_pkt && raw_mode && (cnt_now < cfg.embed_cnt)
        |=> cfg.dtype == $past(cfg.embed_val) && cfg.dtype_valid)
        else $error("embedded type not applied");

    a_raw_type_used: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        long_pkt && raw_mode && cfg.embed_cnt == 2'h0 && !raw12_sel
        |=> cfg.dtype == $past(raw10_type_value))
        else $error("raw type not applied");

    a_csi_untouched: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        long_pkt && !raw_mode |=> cfg.dtype == $past(csi_dtype))
        else $error("csi type altered");

    a_resp_mismatch: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        resp_valid && cfg.enh_en && resp_returned != resp_expected
        |=> cfg.resp_err)
        else $error("response mismatch missed");

endmodule
`default_nettype wire

/* File: inc/rpc_lane_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface rpc_lane_if;
    logic [1:0] embed_cnt;
    logic [5:0] embed_val;
    logic       enh_en;
    logic       resp_err;
    logic [5:0] dtype;
    logic       dtype_valid;

    modport hub  (output embed_cnt, output embed_val, output enh_en,
                  input resp_err, input dtype, input dtype_valid);
    modport lane (input embed_cnt, input embed_val, input enh_en,
                  output resp_err, output dtype, output dtype_valid);
endinterface
`default_nettype wire

/* File: inc/rpc_pkg.sv */
package rpc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_CC_STATUS  = 8'h47;
    localparam logic [7:0] ADDR_LINK_CAP   = 8'h4A;
    localparam logic [7:0] ADDR_RAW_EMBED  = 8'h4B;
    localparam logic [7:0] ADDR_PAGE_SEL   = 8'h4C;
    localparam logic [7:0] ADDR_PAGE_LO    = 8'h4D;
    localparam logic [7:0] ADDR_PAGE_HI    = 8'h7F;
    localparam logic [7:0] ADDR_PAGE2_LO   = 8'hD0;
    localparam logic [7:0] ADDR_PAGE2_HI   = 8'hDF;

    // ==========================================================
    // Field positions
    localparam int CAP_CRC_EN_BIT    = 4;
    localparam int STS_SEQ_BIT       = 5;
    localparam int STS_RESP_BIT      = 0;
    localparam int SEL_PHYS_LSB      = 6;
    localparam int SEL_RD_LSB        = 4;
    localparam int EMB_CNT_LSB       = 6;

    // ==========================================================
    // Reset values; page copies ordered local, then channel 0..3
    localparam logic [7:0]  RAW_EMBED_RST = 8'h12;
    localparam logic [9:0]  PAGE_RD_RST   = 10'h390;
    localparam logic [19:0] PAGE_WR_RST   = 20'h84210;

    localparam int NUM_PORTS = 4;
    localparam int NUM_SRCS  = 5;

    typedef struct packed {
        logic [NUM_SRCS-1:0][1:0]  rd_sel;
        logic [NUM_SRCS-1:0][3:0]  wr_en;
        logic [3:0]                crc_cap;
        logic [3:0][7:0]           embed;
        logic [3:0]                resp_err;
        logic [3:0]                seq_err;
        logic [3:0]                crc_flag;
        logic [7:0]                rd_data;
        logic                      rd_valid;
    } rpc_state_t;

    localparam rpc_state_t RPC_STATE_RST = '{
        rd_sel:   PAGE_RD_RST,
        wr_en:    PAGE_WR_RST,
        crc_cap:  4'h0,
        embed:    {4{RAW_EMBED_RST}},
        resp_err: 4'h0,
        seq_err:  4'h0,
        crc_flag: 4'h0,
        rd_data:  8'h00,
        rd_valid: 1'b0
    };

    typedef struct packed {
        logic [1:0] pkt_cnt;
        logic [5:0] dtype;
        logic       dtype_valid;
        logic       resp_err;
    } rpc_lane_state_t;

    localparam rpc_lane_state_t RPC_LANE_RST = '{
        pkt_cnt: 2'h0, dtype: 6'h00, dtype_valid: 1'b0, resp_err: 1'b0
    };

endpackage

/* File: sim/rpc_hub_test.sv */
`timescale 1ns/100ps
`default_nettype none
module rpc_hub_test;
    import rpc_pkg::*;

    logic            sys_clk, arst_n, acc_valid, acc_write, acc_bcc;
    logic [1:0]      acc_port, send_port;
    logic [7:0]      acc_addr, acc_wdata, rd_data, rd_q, v, send_data;
    logic            rd_valid, enh_en, send, corrupt;
    logic [3:0]      port_seq_err, enc_crc_err, enc_crc_flag, raw_mode, m;
    logic [3:0]      seq_evt;
    logic [3:0]      frame_start, long_pkt, raw12_sel, pkt_valid, resp_valid;
    logic [3:0][5:0] csi_dtype, raw10_val, raw12_val, pkt_dtype;
    logic [3:0][7:0] resp_expected, resp_returned;
    logic [7:0]      emb_m [4];
    integer          num_errors, total_checks, seed, i, p, c, t;

    // ==========================================================
    // Clock, design and far side
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    rpc_hub i_rpc_hub (
        .sys_clk(sys_clk), .arst_n(arst_n), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_bcc(acc_bcc), .acc_port(acc_port),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .rd_data(rd_data),
        .rd_valid(rd_valid), .enhanced_error_check_en(enh_en),
        .port_seq_err(port_seq_err), .seq_err_evt(seq_evt),
        .enc_crc_err(enc_crc_err), .enc_crc_flag(enc_crc_flag),
        .raw_mode(raw_mode), .frame_start(frame_start),
        .long_pkt(long_pkt), .csi_dtype(csi_dtype), .raw12_sel(raw12_sel),
        .raw10_type_value(raw10_val), .raw12_type_value(raw12_val),
        .pkt_dtype(pkt_dtype), .pkt_valid(pkt_valid),
        .resp_valid(resp_valid), .resp_expected(resp_expected),
        .resp_returned(resp_returned)
    );

    rpc_serializer_model i_rpc_serializer_model (
        .sys_clk(sys_clk), .send(send), .port(send_port),
        .data(send_data), .corrupt(corrupt), .resp_valid(resp_valid),
        .resp_expected(resp_expected), .resp_returned(resp_returned)
    );

    // ==========================================================
    // Tasks and expectations
    task automatic results;
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic acc(input logic wr, input logic bcc, input logic [1:0] pt,
                       input logic [7:0] a, input logic [7:0] d);
        integer k;
        @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc_write <= wr;
        acc_bcc   <= bcc;
        acc_port  <= pt;
        acc_addr  <= a;
        acc_wdata <= d;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        if (!wr) begin
            #1;
            k = 0;
            while (rd_valid !== 1'b1 && k < 4) begin
                @(posedge sys_clk);
                #1;
                k = k + 1;
            end
            if (k == 4) begin
                num_errors = num_errors + 1;
                results();
            end
            rd_q = rd_data;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, 2'h0, a, d);
    endtask

    task automatic rdchk(input string name, input logic bcc,
                         input logic [1:0] pt, input logic [7:0] a,
                         input logic [7:0] exp);
        acc(1'b0, bcc, pt, a, 8'h00);
        chk(name, rd_q, exp);
    endtask

    task automatic resp(input logic bad);
        @(posedge sys_clk);
        send      <= 1'b1;
        send_port <= 2'h2;
        send_data <= $random(seed);
        corrupt   <= bad;
        @(posedge sys_clk);
        send <= 1'b0;
        // Sticky bit lands two cycles after the echo, one cycle after the lane check
        repeat (3) @(posedge sys_clk);
    endtask

    function automatic logic [7:0] sel_exp(input integer q);
        return {q[1:0], q[1:0], 4'h1 << q};
    endfunction

    function automatic logic [5:0] exp_dt(input integer q, input integer n,
                                          input integer cnt,
                                          input logic [5:0] ev);
        if (!raw_mode[q])
            return csi_dtype[q];
        if (n < cnt)
            return ev;
        return raw12_sel[q] ? raw12_val[q] : raw10_val[q];
    endfunction

    // ==========================================================
    // Main sequence
    initial begin
        seed = 32'h5EAB;
        num_errors = 0;
        total_checks = 0;
        {acc_valid, acc_write, acc_bcc, acc_port} = '0;
        {acc_addr, acc_wdata, send, corrupt, send_port, send_data} = '0;
        {enh_en, port_seq_err, seq_evt, enc_crc_err, raw_mode} = '0;
        {frame_start, long_pkt, raw12_sel} = '0;
        csi_dtype = $random(seed);
        raw10_val = $random(seed);
        raw12_val = $random(seed);
        for (p = 0; p < 4; p++)
            emb_m[p] = RAW_EMBED_RST;
        arst_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (p = 0; p < 4; p++)
            rdchk("sel_bcc", 1'b1, p[1:0], ADDR_PAGE_SEL,
                  sel_exp(p));
        rdchk("sel_loc", 1'b0, 2'h0, ADDR_PAGE_SEL, 8'h00);
        rdchk("cap_rst", 1'b0, 2'h0, ADDR_LINK_CAP, 8'h00);
        wr(ADDR_RAW_EMBED, 8'h55);
        rdchk("no_wen", 1'b0, 2'h0, ADDR_RAW_EMBED, RAW_EMBED_RST);
        // Random broadcast masks, then per-port readback
        for (t = 0; t < 6; t++) begin
            m = (t == 0) ? 4'hF : $random(seed);
            v = $random(seed);
            wr(ADDR_PAGE_SEL, {4'h0, m});
            wr(ADDR_RAW_EMBED, v);
            for (p = 0; p < 4; p++) begin
                if (m[p])
                    emb_m[p] = v;
                wr(ADDR_PAGE_SEL, {2'b00, p[1:0], m});
                rdchk("emb", 1'b0, 2'h0, ADDR_RAW_EMBED,
                      emb_m[p]);
            end
            rdchk("sel_rd", 1'b0, 2'h0, ADDR_PAGE_SEL,
                  {4'h3, m});
        end
        rdchk("bcc_page", 1'b1, 2'h2, ADDR_PAGE_SEL, sel_exp(2));
        // Channel writes land in the carrier's page, local page untouched
        acc(1'b1, 1'b1, 2'h1, ADDR_RAW_EMBED, 8'hA5);
        rdchk("bcc_wr", 1'b1, 2'h1, ADDR_RAW_EMBED, 8'hA5);
        acc(1'b1, 1'b1, 2'h1, ADDR_PAGE_SEL, 8'h34);
        rdchk("bcc_sel", 1'b1, 2'h1, ADDR_PAGE_SEL, 8'h74);
        rdchk("loc_kept", 1'b0, 2'h0, ADDR_PAGE_SEL, {4'h3, m});
        wr(ADDR_PAGE_SEL, 8'h03);
        wr(ADDR_LINK_CAP, 8'hFF);
        wr(ADDR_PAGE_SEL, 8'h0C);
        wr(ADDR_LINK_CAP, 8'h00);
        wr(8'h50, 8'hFF);
        rdchk("cap", 1'b0, 2'h0, ADDR_LINK_CAP, 8'h10);
        rdchk("unmapped", 1'b0, 2'h0, 8'h50, 8'h00);
        enc_crc_err <= 4'hF;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("crc_flag", {4'h0, enc_crc_flag}, 8'h03);
        enc_crc_err <= 4'h0;
        // Packet typing for every embed count, raw and CSI-2 mixed
        wr(ADDR_PAGE_SEL, 8'h0F);
        for (c = 0; c < 4; c++) begin
            v = $random(seed);
            wr(ADDR_RAW_EMBED, {c[1:0], v[5:0]});
            raw_mode <= (c == 0) ? 4'hF : $random(seed);
            raw12_sel <= $random(seed);
            csi_dtype <= $random(seed);
            for (i = 0; i < 5; i++) begin
                @(posedge sys_clk);
                frame_start <= (i == 0) ? 4'hF : 4'h0;
                long_pkt <= 4'hF;
                @(posedge sys_clk);
                frame_start <= 4'h0;
                long_pkt <= 4'h0;
                #1;
                for (p = 0; p < 4; p++) begin
                    chk("pkt_valid", {7'h0, pkt_valid[p]}, 8'h01);
                    chk("pkt_dtype",
                        {2'b00, pkt_dtype[p]},
                        {2'b00, exp_dt(p, i, c, v[5:0])});
                end
            end
        end
        // Response checking on port 2, read page 2
        enh_en <= 1'b1;
        wr(ADDR_PAGE_SEL, 8'h20);
        rdchk("sts_pre", 1'b0, 2'h0, ADDR_CC_STATUS, 8'h00);
        resp(1'b1);
        rdchk("resp_err", 1'b0, 2'h0, ADDR_CC_STATUS, 8'h01);
        rdchk("resp_clr", 1'b0, 2'h0, ADDR_CC_STATUS, 8'h00);
        resp(1'b0);
        rdchk("resp_ok", 1'b0, 2'h0, ADDR_CC_STATUS, 8'h00);
        // Sticky sequence flag while enhanced checking is on
        seq_evt <= 4'h4;
        @(posedge sys_clk);
        seq_evt <= 4'h0;
        rdchk("seq_stk", 1'b0, 2'h0, ADDR_CC_STATUS, 8'h20);
        rdchk("seq_clr", 1'b0, 2'h0, ADDR_CC_STATUS, 8'h00);
        enh_en <= 1'b0;
        resp(1'b1);
        rdchk("resp_off", 1'b0, 2'h0, ADDR_CC_STATUS, 8'h00);
        port_seq_err <= 4'h4;
        for (i = 0; i < 2; i++)
            rdchk("seq_mir", 1'b0, 2'h0, ADDR_CC_STATUS, 8'h20);
        port_seq_err <= 4'h0;
        rdchk("seq_low", 1'b0, 2'h0, ADDR_CC_STATUS, 8'h00);
        results();
    end
endmodule
`default_nettype wire

/* File: sim/rpc_serializer_model.sv */
`timescale 1ns/100ps
`default_nettype none
module rpc_serializer_model (
    input  wire logic            sys_clk,
    input  wire logic            send,
    input  wire logic [1:0]      port,
    input  wire logic [7:0]      data,
    input  wire logic            corrupt,
    output logic      [3:0]      resp_valid,
    output logic      [3:0][7:0] resp_expected,
    output logic      [3:0][7:0] resp_returned
);
    // ==========================================================
    // Echo of each command byte, one bit flipped on request
    initial begin
        resp_valid    = 4'h0;
        resp_expected = '0;
        resp_returned = '1;
    end

    always @(posedge sys_clk) begin
        resp_valid <= send ? (4'h1 << port) : 4'h0;
        resp_expected[port] <= data;
        if (send)
            resp_returned[port] <= corrupt ? data ^ 8'h01 : data;
        else
            // Idle lines toggle so a stale echo never looks valid
            resp_returned <= ~resp_returned;
    end
endmodule
`default_nettype wire
